// *** include/rx_pkg.sv ***
// Package of register offsets, field positions, codes and timing for the listener receive block.
package rx_pkg;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] CMD_OFF = 8'h04;
    localparam logic [7:0] COUNT_OFF = 8'h08;
    localparam logic [7:0] STATUS_OFF = 8'h0C;
    localparam logic [7:0] RXCNT_OFF = 8'h10;
    localparam logic [7:0] ADDR_OFF = 8'h14;
    localparam logic [7:0] TERM_OFF = 8'h18;
    localparam logic [7:0] IOTMO_OFF = 8'h1C;
    localparam logic [7:0] MSGTMO_OFF = 8'h20;
    localparam logic [7:0] DMACH_OFF = 8'h24;
    localparam logic [7:0] RDATA_OFF = 8'h28;
    localparam logic [7:0] WORD_OFF = 8'h2C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_TERM_EN = 0;
    localparam int CTRL_TSEL_LO = 1;
    localparam int CTRL_CIC = 3;
    localparam int CMD_START_LO = 0;
    localparam int CMD_TALKER_LO = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_CAUSE_LO = 4;
    localparam int ADDR_LA = 0;
    localparam int ADDR_TA = 1;
    localparam int ADDR_REN = 2;
    localparam int ADDR_TALKEN = 3;

    // Start codes written to the command register.
    localparam logic [1:0] OP_ENTER = 2'h1;
    localparam logic [1:0] OP_STRING = 2'h2;
    localparam logic [1:0] OP_ARRAY = 2'h3;

    // End causes reported in the status byte.
    localparam logic [2:0] END_NONE = 3'h0;
    localparam logic [2:0] END_EOI = 3'h1;
    localparam logic [2:0] END_TERM = 3'h2;
    localparam logic [2:0] END_FULL = 3'h3;
    localparam logic [2:0] END_IOTMO = 3'h4;
    localparam logic [2:0] END_MSGTMO = 3'h5;
    localparam logic [2:0] END_NOTADDR = 3'h6;

    localparam logic [7:0] CR_BYTE = 8'h0D;
    localparam logic [1:0] DMA_CH_LO = 2'h1;
    localparam logic [16:0] MAX_COUNT = 17'h10000;
    localparam logic [31:0] RESET_TERM = 32'h0D0A0A0D;

    // Timing: 50 MHz clock, one millisecond tick for the timeouts.
    localparam int CLK_HZ = 50000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
    localparam int MSG_TMO_S = 10;
    localparam logic [15:0] MSG_TMO_TICKS = 16'(MSG_TMO_S * 1000000 / TICK_US);
    localparam logic [15:0] IO_TMO_TICKS = 16'h03E8;
endpackage

// *** core/gpib_listener_receive_dma.sv ***
// Listener receive engine with APB registers and a 32-bit word DMA request port.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module gpib_listener_receive_dma #(
    parameter int TICK_CYC = rx_pkg::TICK_CYCLES
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received byte stream from the bus transceiver
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic byte_eoi,
    input wire logic listen_addressed_flag,
    input wire logic talk_addressed_flag,
    output logic byte_ready,
    // Bus addressing commands
    output logic listen_self,
    output logic talk_remote,
    output logic [4:0] talker_addr,
    output logic remote_enable,
    output logic untalk_unlisten,
    // Host DMA handshake
    output logic dma_request_line,
    input wire logic dma_ack,
    output logic [31:0] dma_word
);
    // ****************************************************************
    // State and registers
    // ****************************************************************
    typedef enum logic [1:0] {IDLE, RUN, FLUSH, FINISH} state_t;
    state_t state_q, state_d;
    logic [1:0] mode_q;
    logic term_en_q, cic_q;
    logic [1:0] tsel_q;
    logic [16:0] count_q;
    logic [16:0] rxcnt_q;
    logic [31:0] term_q;
    logic [15:0] iotmo_q, msgtmo_q;
    logic [7:0] dmach_q;
    logic [2:0] cause_q;
    logic done_q;
    logic [31:0] word_q;
    logic [1:0] lane_q;
    logic word_full_q;
    logic [15:0] io_ticks_q, msg_ticks_q;
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [2:0] end_cause;

    // Picks one of the four terminator bytes from the packed setting.
    function automatic logic [7:0] term_byte(input logic [31:0] t, input logic [1:0] s);
        term_byte = t[8*s +: 8];
    endfunction

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire wr = psel && penable && pwrite;
    wire rd_setup = psel && !penable;
    wire wr_cmd = wr && paddr == rx_pkg::CMD_OFF;
    wire [1:0] start_op = pwdata[rx_pkg::CMD_START_LO +: 2];
    // Every mapped offset; any other address answers with an error.
    wire known = paddr == rx_pkg::CTRL_OFF
        || paddr == rx_pkg::CMD_OFF
        || paddr == rx_pkg::COUNT_OFF
        || paddr == rx_pkg::STATUS_OFF
        || paddr == rx_pkg::RXCNT_OFF
        || paddr == rx_pkg::ADDR_OFF
        || paddr == rx_pkg::TERM_OFF
        || paddr == rx_pkg::IOTMO_OFF
        || paddr == rx_pkg::MSGTMO_OFF
        || paddr == rx_pkg::DMACH_OFF
        || paddr == rx_pkg::RDATA_OFF
        || paddr == rx_pkg::WORD_OFF;
    wire dma_on = dmach_q >= 8'(rx_pkg::DMA_CH_LO) && dmach_q <= 8'h03;
    wire [7:0] status_byte = {1'b0, cause_q, 2'b00, done_q, state_q != IDLE};

    // Read mux; address flags come straight from the transceiver.
    logic [31:0] rmux;
    always_comb begin
        case (paddr)
            rx_pkg::CTRL_OFF: rmux = {28'h0, cic_q, tsel_q, term_en_q};
            rx_pkg::COUNT_OFF: rmux = {15'h0, count_q};
            rx_pkg::STATUS_OFF: rmux = {24'h0, status_byte};
            rx_pkg::RXCNT_OFF: rmux = {15'h0, rxcnt_q};
            rx_pkg::ADDR_OFF: rmux = {28'h0, talk_remote, remote_enable, talk_addressed_flag,
                listen_addressed_flag};
            rx_pkg::TERM_OFF: rmux = term_q;
            rx_pkg::IOTMO_OFF: rmux = {16'h0, iotmo_q};
            rx_pkg::MSGTMO_OFF: rmux = {16'h0, msgtmo_q};
            rx_pkg::DMACH_OFF: rmux = {24'h0, dmach_q};
            rx_pkg::WORD_OFF: rmux = dma_word;
            default: rmux = 32'h0;
        endcase
    end

    // Zero-wait slave: pready high in every access phase, error on unmapped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pslverr <= rd_setup && !known;
            if (rd_setup) begin
                prdata <= rmux;
            end
        end
    end
    // Registered like every other output; no wait state is ever inserted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b1;
        end else begin
            pready <= 1'b1;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    // Writes land at the access edge only, so one transfer changes a register once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_en_q <= 1'b0;
            tsel_q <= 2'h0;
            cic_q <= 1'b0;
            count_q <= rx_pkg::MAX_COUNT;
            term_q <= rx_pkg::RESET_TERM;
            iotmo_q <= rx_pkg::IO_TMO_TICKS;
            msgtmo_q <= rx_pkg::MSG_TMO_TICKS;
            dmach_q <= 8'h0;
        end else if (wr) begin
            case (paddr)
                rx_pkg::CTRL_OFF: begin
                    term_en_q <= pwdata[rx_pkg::CTRL_TERM_EN];
                    tsel_q <= pwdata[rx_pkg::CTRL_TSEL_LO +: 2];
                    cic_q <= pwdata[rx_pkg::CTRL_CIC];
                end
                rx_pkg::COUNT_OFF: count_q <= (pwdata[16:0] > rx_pkg::MAX_COUNT) ? rx_pkg::MAX_COUNT
                    : pwdata[16:0];
                rx_pkg::TERM_OFF: term_q <= pwdata;
                rx_pkg::IOTMO_OFF: iotmo_q <= pwdata[15:0];
                rx_pkg::MSGTMO_OFF: msgtmo_q <= pwdata[15:0];
                rx_pkg::DMACH_OFF: dmach_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Byte classification
    // ****************************************************************
    wire is_term = byte_data == term_byte(term_q, tsel_q);
    wire string_mode = mode_q != rx_pkg::OP_ARRAY;
    wire drop = string_mode && (byte_data == rx_pkg::CR_BYTE || is_term);
    // no byte value is special in array mode besides an enabled terminator
    wire term_hit = string_mode ? is_term : (term_en_q && is_term);
    wire take = state_q == RUN && byte_valid && byte_ready;
    wire store = take && !drop;
    wire [16:0] rx_next = rxcnt_q + 17'h1;

    // Millisecond tick divider for both timeouts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_cnt_q == 32'(TICK_CYC - 1);
            tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    // End cause in priority: address loss, terminator, EOI, count, timeouts; in array mode EOI beats the terminator.
    // Address loss wins, since bytes seen while unaddressed are not meant for us.
    always_comb begin
        end_cause = rx_pkg::END_NONE;
        if (state_q == RUN) begin
            if (mode_q != rx_pkg::OP_ENTER && !listen_addressed_flag) begin
                end_cause = rx_pkg::END_NOTADDR;
            end else if (take && byte_eoi && !(string_mode && term_hit)) begin
                end_cause = rx_pkg::END_EOI;
            end else if (take && term_hit) begin
                end_cause = rx_pkg::END_TERM;
            end else if (take && byte_eoi) begin
                end_cause = rx_pkg::END_EOI;
            end else if (store && rx_next >= count_q) begin
                end_cause = rx_pkg::END_FULL;
            end else if (tick_q && io_ticks_q >= iotmo_q) begin
                end_cause = rx_pkg::END_IOTMO;
            end else if (tick_q && dma_on && msg_ticks_q >= msgtmo_q) begin
                end_cause = rx_pkg::END_MSGTMO;
            end
        end
    end

    // ****************************************************************
    // Receive sequencer
    // ****************************************************************
    // A start while busy is ignored, so a stray write cannot cut a running receive.
    wire start_ok = wr_cmd && state_q == IDLE && start_op != 2'h0;
    wire start_ref = start_op == rx_pkg::OP_ENTER ? !cic_q : !listen_addressed_flag;
    // Next state; FLUSH waits until the host has taken a full pending word, but a partial word is flushed as it leaves.
    always_comb begin
        state_d = state_q;
        case (state_q)
            IDLE: begin
                if (start_ok && !start_ref) state_d = RUN;
            end
            RUN: begin
                if (end_cause != rx_pkg::END_NONE) state_d = FLUSH;
            end
            FLUSH: begin
                if (!word_full_q) state_d = FINISH;
            end
            FINISH: state_d = IDLE;
            default: state_d = IDLE;
        endcase
    end

    // The stored count and both timeout counters restart with every accepted start.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= IDLE;
            mode_q <= rx_pkg::OP_STRING;
            cause_q <= rx_pkg::END_NONE;
            done_q <= 1'b0;
            rxcnt_q <= 17'h0;
            io_ticks_q <= 16'h0;
            msg_ticks_q <= 16'h0;
        end else begin
            state_q <= state_d;
            if (start_ok) begin
                mode_q <= start_op;
                rxcnt_q <= 17'h0;
                io_ticks_q <= 16'h0;
                msg_ticks_q <= 16'h0;
                done_q <= start_ref;
                cause_q <= start_ref ? rx_pkg::END_NOTADDR : rx_pkg::END_NONE;
            end else if (state_q == RUN) begin
                if (store) rxcnt_q <= rx_next;
                io_ticks_q <= take ? 16'h0 : (tick_q ? io_ticks_q + 16'h1 : io_ticks_q);
                if (tick_q) msg_ticks_q <= msg_ticks_q + 16'h1;
                if (end_cause != rx_pkg::END_NONE) cause_q <= end_cause;
            end else if (state_q == FINISH) begin
                done_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Bus addressing outputs
    // ****************************************************************
    // Remote enable stays set once raised; only reset clears it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            listen_self <= 1'b0;
            talk_remote <= 1'b0;
            talker_addr <= 5'h0;
            remote_enable <= 1'b0;
            untalk_unlisten <= 1'b0;
        end else begin
            untalk_unlisten <= 1'b0;
            if (start_ok && !start_ref && start_op == rx_pkg::OP_ENTER) begin
                // self listen, instrument talk, remote enable
                listen_self <= 1'b1;
                talk_remote <= 1'b1;
                talker_addr <= pwdata[rx_pkg::CMD_TALKER_LO +: 5];
                remote_enable <= 1'b1;
            end else if (state_q == FINISH && mode_q == rx_pkg::OP_ENTER) begin
                listen_self <= 1'b0;
                talk_remote <= 1'b0;
                untalk_unlisten <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Word packing and DMA handshake
    // ****************************************************************
    // Back-pressure: the listener stalls while a packed word awaits the host.
    // Upper bytes of a flushed partial word are stale; the stored count tells how many hold data.
    wire word_take = dma_on ? (dma_request_line && dma_ack)
        : (psel && penable && !pwrite && paddr == rx_pkg::WORD_OFF);
    wire last_flush = state_q == FLUSH && lane_q != 2'h0 && !word_full_q;
    // Ready is worked out a cycle ahead, so the fourth byte of a word is the last one taken.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_q <= 32'h0;
            lane_q <= 2'h0;
            word_full_q <= 1'b0;
            byte_ready <= 1'b0;
            dma_word <= 32'h0;
            dma_request_line <= 1'b0;
        end else begin
            byte_ready <= state_d == RUN && !word_full_q && !(store && lane_q == 2'h3);
            if (word_full_q && word_take) begin
                word_full_q <= 1'b0;
            end else if ((store && lane_q == 2'h3) || last_flush) begin
                word_full_q <= 1'b1;
            end
            if (store) begin
                word_q[8*lane_q +: 8] <= byte_data;
                lane_q <= lane_q + 2'h1;
                if (lane_q == 2'h3) dma_word <= {byte_data, word_q[23:0]};
            end else if (last_flush) begin
                dma_word <= word_q;
                lane_q <= 2'h0;
            end
            if (start_ok) begin
                word_q <= 32'h0;
                lane_q <= 2'h0;
            end
            dma_request_line <= dma_on && word_full_q && !word_take && !dma_request_line ? 1'b1
                : (dma_request_line && !dma_ack && word_full_q);
        end
    end
endmodule
`default_nettype wire

// *** sim/rx_chk.sv ***
// Port-level checker for the listener receive block.
`timescale 1ns/1ns
`default_nettype none
module rx_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic listen_self,
    input wire logic talk_remote,
    input wire logic remote_enable,
    input wire logic untalk_unlisten,
    input wire logic dma_request_line,
    input wire logic dma_ack,
    input wire logic [31:0] dma_word
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A word offered for DMA waits for the acknowledge, then is handed over once.
    sequence s_offer; dma_request_line && !dma_ack; endsequence
    sequence s_taken; dma_request_line && dma_ack; endsequence
    // The slave never stretches a transfer and only flags errors in the access phase.
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
    a_req_held: assert property (s_offer |=> dma_request_line && $stable(dma_word))
        else $error("DMA request or word changed before acknowledge");
    a_req_drop: assert property (s_taken |=> !dma_request_line)
        else $error("DMA request stayed up after acknowledge");
    a_unt_pulse: assert property (untalk_unlisten |=> !untalk_unlisten)
        else $error("untalk pulse longer than one cycle");
    a_unt_clear: assert property (untalk_unlisten |-> ##[0:2] (!listen_self && !talk_remote))
        else $error("addressing kept after untalk");
    a_ren_sticky: assert property (remote_enable |=> remote_enable)
        else $error("remote enable dropped");
    a_talk_pair: assert property ($rose(talk_remote) |-> ##[0:2] (listen_self && remote_enable))
        else $error("talker addressed without self listen and remote enable");
endmodule
bind gpib_listener_receive_dma rx_chk i_rx_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .listen_self, .talk_remote, .remote_enable, .untalk_unlisten, .dma_request_line, .dma_ack, .dma_word);
`default_nettype wire

// *** sim/talker_dma_model.sv ***
// Talker instrument and host DMA controller model for the receive bench.
`timescale 1ns/1ns
`default_nettype none
module talker_dma_model (
    // Clock
    input wire logic pclk,
    // Byte stream towards the receiver
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic byte_eoi,
    input wire logic byte_ready,
    // DMA handshake
    input wire logic dma_request_line,
    output logic dma_ack,
    input wire logic [31:0] dma_word
);
    logic [8:0] q[$];
    logic [7:0] got[$];
    int seed = 17;
    int wait_n = 0;
    initial {byte_valid, byte_data, byte_eoi, dma_ack} = '0;
    // One byte is offered at a time; an idle data line toggles so stale data never looks valid.
    always @(posedge pclk) begin
        if (byte_valid && byte_ready && q.size() > 0) void'(q.pop_front());
        if (q.size() > 0) begin
            byte_valid <= 1'b1;
            {byte_eoi, byte_data} <= q[0];
        end else begin
            byte_valid <= 1'b0;
            byte_eoi <= 1'b0;
            byte_data <= ~byte_data;
        end
    end
    // controller moves data
    // Arbitration delay of 0 to 3 cycles, so both prompt and slow answers occur.
    always @(posedge pclk) begin
        dma_ack <= 1'b0;
        if (dma_request_line && dma_ack) begin
            for (int i = 0; i < 4; i++) got.push_back(dma_word[8*i +: 8]);
        end else if (dma_request_line) begin
            if (wait_n == 0) begin
                dma_ack <= 1'b1;
                wait_n = $unsigned($random(seed)) % 4;
            end else begin
                wait_n = wait_n - 1;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/tb_gpib_listener_receive_dma.sv ***
// Self-checking bench for the listener receive block.
`timescale 1ns/1ns
`default_nettype none
module tb_gpib_listener_receive_dma;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, byte_data, t;
    logic [31:0] pwdata, prdata, dma_word, rd, pw;
    logic byte_valid, byte_eoi, byte_ready, listen_addressed_flag, talk_addressed_flag;
    logic listen_self, talk_remote, remote_enable, untalk_unlisten, dma_request_line, dma_ack;
    logic [4:0] talker_addr, ta, seen_ta;
    logic [8:0] src[$];
    logic [7:0] exp[$];
    int n_fail = 0, tests_run = 0, seed = 17, n_unt = 0, n_req = 0;

    gpib_listener_receive_dma #(.TICK_CYC(10)) i_gpib_listener_receive_dma (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .byte_valid, .byte_data, .byte_eoi,
        .listen_addressed_flag, .talk_addressed_flag, .byte_ready, .listen_self, .talk_remote, .talker_addr,
        .remote_enable, .untalk_unlisten, .dma_request_line, .dma_ack, .dma_word);
    talker_dma_model i_talker_dma_model (.pclk, .byte_valid, .byte_data, .byte_eoi, .byte_ready,
        .dma_request_line, .dma_ack, .dma_word);

    // Free-running 50 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // Counts untalk pulses and cycles with a DMA request up, and keeps the last addressed talker.
    always @(posedge pclk) begin
        if (untalk_unlisten === 1'b1) n_unt = n_unt + 1;
        if (dma_request_line === 1'b1) n_req = n_req + 1;
        if (talk_remote === 1'b1) seen_ta = talker_addr;
    end
    // A hung handshake must not stall the run forever.
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        tests_run++;
        if (got !== want) begin
            n_fail++;
            $display("BAD %0t %s: got %h, want %h", $time, what, got, want);
        end
    endtask
    // One APB transfer; an idle edge first keeps release and the next setup apart.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Random bytes; with avoid set, terminator and carriage return are moved out of the way.
    task automatic fill(input int n, input logic avoid);
        logic [7:0] b;
        src.delete();
        repeat (n) begin
            b = 8'($random(seed));
            if (avoid && (b == t || b == rx_pkg::CR_BYTE)) b = b ^ 8'h80;
            src.push_back({1'b0, b});
        end
    endtask
    // Works out the stored bytes and the end cause from the offered bytes.
    function automatic logic [2:0] expect_rx(input logic [1:0] op, input logic ten, input int cap);
        exp.delete();
        foreach (src[i]) begin
            if (op != rx_pkg::OP_ARRAY && src[i][7:0] == t) return rx_pkg::END_TERM;
            if (op == rx_pkg::OP_ARRAY || src[i][7:0] != rx_pkg::CR_BYTE) exp.push_back(src[i][7:0]);
            if (ten && src[i][7:0] == t) return rx_pkg::END_TERM;
            if (src[i][8]) return rx_pkg::END_EOI;
            if (exp.size() == cap) return rx_pkg::END_FULL;
        end
        return (src.size() > 0) ? rx_pkg::END_IOTMO : rx_pkg::END_MSGTMO;
    endfunction
    // Starts one receive, lets the talker offer the bytes and checks what was stored.
    task automatic run(input logic [1:0] op, input logic ten, input int cap, input logic refuse, input logic dma);
        logic [2:0] cause;
        int k, u;
        cause = refuse ? rx_pkg::END_NOTADDR : expect_rx(op, ten, cap);
        if (refuse) exp.delete();
        u = n_unt;
        pw = 32'h0;
        k = 0;
        ta = 5'($unsigned($random(seed)) % 31);
        apb(1'b1, rx_pkg::CMD_OFF, {19'h0, ta, 6'h0, op});
        foreach (src[i]) i_talker_dma_model.q.push_back(src[i]);
        do begin
            if (!dma) begin
                apb(1'b0, rx_pkg::WORD_OFF, 32'h0);
                if (rd !== 32'h0) pw = rd;
            end
            apb(1'b0, rx_pkg::STATUS_OFF, 32'h0);
            k++;
        end while (rd[rx_pkg::ST_DONE] !== 1'b1 && k < 500);
        chk(32'(rd[rx_pkg::ST_CAUSE_LO +: 3]), 32'(cause), "end cause");
        apb(1'b0, rx_pkg::RXCNT_OFF, 32'h0);
        chk(rd, 32'(exp.size()), "stored count");
        repeat (8) @(posedge pclk);
        if (dma) begin
            foreach (exp[i]) chk(32'(i_talker_dma_model.got[i]), 32'(exp[i]), "stored byte");
        end else begin
            apb(1'b0, rx_pkg::WORD_OFF, 32'h0);
            if (rd !== 32'h0) pw = rd;
            chk(pw, {exp[3], exp[2], exp[1], exp[0]}, "packed word");
        end
        if (op == rx_pkg::OP_ENTER && !refuse) begin
            chk(32'(seen_ta), 32'(ta), "talker address");
            chk(32'(remote_enable), 32'h1, "remote enable");
            chk(32'(n_unt - u), 32'h1, "untalk pulses");
        end
        i_talker_dma_model.q.delete();
        i_talker_dma_model.got.delete();
        $display("test op %0d cause %0d done", op, cause);
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence: reset, register defaults, then every way a receive can end.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {listen_addressed_flag, talk_addressed_flag} = 2'b11;
        t = 8'h0A;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, rx_pkg::COUNT_OFF, 32'h0);
        chk(rd, 32'h00010000, "count reset");
        apb(1'b0, rx_pkg::TERM_OFF, 32'h0);
        chk(rd, rx_pkg::RESET_TERM, "terminator reset");
        apb(1'b0, rx_pkg::MSGTMO_OFF, 32'h0);
        chk(rd, 32'h00002710, "message timeout reset");
        apb(1'b0, 8'h30, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000, "unmapped read");
        apb(1'b0, rx_pkg::ADDR_OFF, 32'h0);
        chk(rd, 32'((1 << rx_pkg::ADDR_LA) | (1 << rx_pkg::ADDR_TA)), "address flags");
        apb(1'b1, rx_pkg::TERM_OFF, 32'h7E043B0A);
        apb(1'b1, rx_pkg::DMACH_OFF, 32'h1);
        apb(1'b1, rx_pkg::CTRL_OFF, 32'h0);
        run(rx_pkg::OP_ENTER, 1'b0, 65536, 1'b1, 1'b1);
        listen_addressed_flag <= 1'b0;
        run(rx_pkg::OP_STRING, 1'b0, 65536, 1'b1, 1'b1);
        listen_addressed_flag <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            t = 8'(32'h7E043B0A >> (8 * s));
            apb(1'b1, rx_pkg::CTRL_OFF, 32'(s << 1) | 32'h8);
            fill(6, 1'b1);
            src.insert(3, {1'b0, rx_pkg::CR_BYTE});
            src.push_back({1'b0, t});
            run(rx_pkg::OP_ENTER, 1'b0, 65536, 1'b0, 1'b1);
        end
        fill(5, 1'b1);
        src[4][8] = 1'b1;
        run(rx_pkg::OP_ENTER, 1'b0, 65536, 1'b0, 1'b1);
        apb(1'b1, rx_pkg::COUNT_OFF, 32'h5);
        fill(8, 1'b1);
        run(rx_pkg::OP_STRING, 1'b0, 5, 1'b0, 1'b1);
        apb(1'b1, rx_pkg::COUNT_OFF, 32'h9);
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, rx_pkg::CTRL_OFF, 32'h6 | 32'(e));
            fill(3, 1'b0);
            src.push_back({1'b0, rx_pkg::CR_BYTE});
            src.push_back({1'b0, t});
            src.push_back({1'b0, 8'h00});
            repeat (6) src.push_back({1'b0, 8'($random(seed))});
            run(rx_pkg::OP_ARRAY, e[0], 9, 1'b0, 1'b1);
        end
        apb(1'b1, rx_pkg::DMACH_OFF, 32'h3);
        apb(1'b1, rx_pkg::IOTMO_OFF, 32'h3);
        fill(2, 1'b1);
        run(rx_pkg::OP_ARRAY, 1'b0, 9, 1'b0, 1'b1);
        apb(1'b1, rx_pkg::IOTMO_OFF, 32'h64);
        apb(1'b1, rx_pkg::MSGTMO_OFF, 32'h3);
        src.delete();
        run(rx_pkg::OP_ARRAY, 1'b0, 9, 1'b0, 1'b1);
        apb(1'b1, rx_pkg::DMACH_OFF, 32'h4);
        apb(1'b1, rx_pkg::COUNT_OFF, 32'h4);
        n_req = 0;
        src = '{9'h011, 9'h022, 9'h033, 9'h044};
        run(rx_pkg::OP_ARRAY, 1'b0, 4, 1'b0, 1'b0);
        chk(32'(n_req), 32'h0, "no DMA request");
        summarize();
    end
endmodule
`default_nettype wire
